// [logic/csrb_register_bank.sv]
`timescale 1ns/10ps
// Contract
// - read trigger starts colour reading, self-clears
// - offset trigger starts offset reading, self-clears
// - mode bit 2 selects external clock
// - sleep held only with external clock
// - mode bit 0 enables trim offset
// - per-channel 4-bit gain capacitor count
// - 12-bit slot count split lo/hi bytes
// - 10-bit result split lo/hi bytes
// - offset result sign-magnitude, sign bit 7
module csrb_register_bank #(
  parameter int CHANNELS = csrb_pkg::CSRB_CHANNELS
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [csrb_pkg::CSRB_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [csrb_pkg::CSRB_BYTE_W-1:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [csrb_pkg::CSRB_BYTE_W-1:0] reg_rdata_o,
  // converter
  output logic afe_start_o,
  output logic afe_zero_mode_o,
  input wire logic afe_done_i,
  input wire csrb_pkg::csrb_count_t afe_count_i,
  input wire csrb_pkg::csrb_zero_t afe_zero_i,
  // settings and status
  output csrb_pkg::csrb_cfg_t cfg_o,
  output logic busy_o
);
  import csrb_pkg::*;

  if (CHANNELS != CSRB_CHANNELS) begin : g_bad_channels
    $error("register map serves exactly four channels");
  end

  localparam int HI_SLOT_W = CSRB_SLOT_W - CSRB_BYTE_W;
  localparam int HI_COUNT_W = CSRB_COUNT_W - CSRB_BYTE_W;

  function automatic logic [CSRB_ADDR_W-1:0] addr_at(
    input logic [CSRB_ADDR_W-1:0] base,
    input int idx
  );
    return base + CSRB_ADDR_W'(idx);
  endfunction

  function automatic logic wr_hit(
    input logic wr,
    input logic [CSRB_ADDR_W-1:0] addr,
    input logic [CSRB_ADDR_W-1:0] at
  );
    return wr && (addr == at);
  endfunction

  logic read_trig_r;
  logic zero_trig_r;
  logic outside_clock_select_r;
  logic sleep_r;
  logic trim_r;
  logic [CHANNELS-1:0][CSRB_CAP_W-1:0] gain_caps_r;
  logic [CHANNELS-1:0][CSRB_SLOT_W-1:0] integ_slots_r;
  logic [CHANNELS-1:0][CSRB_COUNT_W-1:0] count_r;
  logic [CHANNELS-1:0][CSRB_BYTE_W-1:0] zero_level_r;
  logic [CSRB_BYTE_W-1:0] rdata_nxt;
  logic read_done;
  logic zero_done;
  logic trig_wr;
  logic mode_wr;

  assign trig_wr = wr_hit(reg_wr_i, reg_addr_i, CSRB_ADDR_TRIGGER);
  assign mode_wr = wr_hit(reg_wr_i, reg_addr_i, CSRB_ADDR_MODE);

  csrb_measure_seq u_seq (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .read_trig_i(read_trig_r),
    .zero_trig_i(zero_trig_r),
    .afe_done_i(afe_done_i),
    .afe_start_o(afe_start_o),
    .afe_zero_mode_o(afe_zero_mode_o),
    .read_done_o(read_done),
    .zero_done_o(zero_done),
    .busy_o(busy_o)
  );

  // triggers: a write of one in the completion cycle wins and reruns;
  // a write of zero cannot abort a running measurement
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      read_trig_r <= 1'b0;
      zero_trig_r <= 1'b0;
    end else begin
      if (trig_wr && reg_wdata_i[CSRB_BIT_READ_TRIG]) begin
        read_trig_r <= 1'b1;
      end else if (read_done) begin
        read_trig_r <= 1'b0;
      end
      if (trig_wr && reg_wdata_i[CSRB_BIT_ZERO_TRIG]) begin
        zero_trig_r <= 1'b1;
      end else if (zero_done) begin
        zero_trig_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      outside_clock_select_r <= 1'b0;
      sleep_r <= 1'b0;
      trim_r <= 1'b0;
    end else if (mode_wr) begin
      outside_clock_select_r <= reg_wdata_i[CSRB_BIT_OUTSIDE_CLOCK_SELECT];
      // sleep without the external clock is dropped at once
      sleep_r <= reg_wdata_i[CSRB_BIT_SLEEP]
                 && reg_wdata_i[CSRB_BIT_OUTSIDE_CLOCK_SELECT];
      trim_r <= reg_wdata_i[CSRB_BIT_TRIM];
    end
  end

  // upper bits of narrow fields are simply not stored
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        gain_caps_r[ch] <= CSRB_CAP_RESET;
        integ_slots_r[ch] <= CSRB_SLOT_RESET;
      end
    end else begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        if (wr_hit(reg_wr_i, reg_addr_i, addr_at(CSRB_ADDR_CAPS, ch))) begin
          gain_caps_r[ch] <= reg_wdata_i[CSRB_CAP_W-1:0];
        end
        if (wr_hit(reg_wr_i, reg_addr_i,
                   addr_at(CSRB_ADDR_SLOTS, 2 * ch))) begin
          integ_slots_r[ch][CSRB_BYTE_W-1:0] <= reg_wdata_i;
        end
        if (wr_hit(reg_wr_i, reg_addr_i,
                   addr_at(CSRB_ADDR_SLOTS, 2 * ch + 1))) begin
          integ_slots_r[ch][CSRB_SLOT_W-1:CSRB_BYTE_W] <=
            reg_wdata_i[HI_SLOT_W-1:0];
        end
      end
    end
  end

  // results are captured whole on completion, so lo and hi always match
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int ch = 0; ch < CHANNELS; ch++) begin
        count_r[ch] <= CSRB_COUNT_RESET;
        zero_level_r[ch] <= CSRB_ZERO_RESET;
      end
    end else begin
      if (read_done) begin
        count_r <= afe_count_i.count;
      end
      if (zero_done) begin
        zero_level_r <= afe_zero_i.level;
      end
    end
  end

  // unmapped addresses and unused bits read zero
  always_comb begin
    rdata_nxt = '0;
    if (reg_addr_i == CSRB_ADDR_TRIGGER) begin
      rdata_nxt[CSRB_BIT_READ_TRIG] = read_trig_r;
      rdata_nxt[CSRB_BIT_ZERO_TRIG] = zero_trig_r;
    end
    if (reg_addr_i == CSRB_ADDR_MODE) begin
      rdata_nxt[CSRB_BIT_OUTSIDE_CLOCK_SELECT] = outside_clock_select_r;
      rdata_nxt[CSRB_BIT_SLEEP] = sleep_r;
      rdata_nxt[CSRB_BIT_TRIM] = trim_r;
    end
    for (int ch = 0; ch < CHANNELS; ch++) begin
      if (reg_addr_i == addr_at(CSRB_ADDR_CAPS, ch)) begin
        rdata_nxt = CSRB_BYTE_W'(gain_caps_r[ch]);
      end
      if (reg_addr_i == addr_at(CSRB_ADDR_SLOTS, 2 * ch)) begin
        rdata_nxt = integ_slots_r[ch][CSRB_BYTE_W-1:0];
      end
      if (reg_addr_i == addr_at(CSRB_ADDR_SLOTS, 2 * ch + 1)) begin
        rdata_nxt = CSRB_BYTE_W'(
          integ_slots_r[ch][CSRB_SLOT_W-1:CSRB_BYTE_W]);
      end
      if (reg_addr_i == addr_at(CSRB_ADDR_RESULT, 2 * ch)) begin
        rdata_nxt = count_r[ch][CSRB_BYTE_W-1:0];
      end
      if (reg_addr_i == addr_at(CSRB_ADDR_RESULT, 2 * ch + 1)) begin
        rdata_nxt = CSRB_BYTE_W'(
          count_r[ch][CSRB_COUNT_W-1:CSRB_BYTE_W]);
      end
      if (reg_addr_i == addr_at(CSRB_ADDR_ZERO, ch)) begin
        rdata_nxt = zero_level_r[ch];
      end
    end
  end

  // read data holds until the next read
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end
  end

  always_comb begin
    cfg_o.outside_clock_select = outside_clock_select_r;
    cfg_o.sleep = sleep_r;
    cfg_o.trim_mode_enable = trim_r;
    cfg_o.gain_caps = gain_caps_r;
    cfg_o.integ_slots = integ_slots_r;
  end

  chk_read_trig_clear: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    read_done && !(trig_wr && reg_wdata_i[CSRB_BIT_READ_TRIG])
    |=> !read_trig_r)
    else $error("read trigger did not clear on completion");

  chk_read_capture: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    read_done |=> count_r == $past(afe_count_i.count))
    else $error("colour result not captured");

  chk_read_starts: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    trig_wr && reg_wdata_i[CSRB_BIT_READ_TRIG] && !busy_o
    |=> ##1 afe_start_o && !afe_zero_mode_o)
    else $error("read trigger did not start a colour run");

  chk_zero_capture: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    zero_done |=> zero_level_r == $past(afe_zero_i.level)
      && (!zero_trig_r
      || $past(trig_wr && reg_wdata_i[CSRB_BIT_ZERO_TRIG])))
    else $error("offset result not captured or trigger stuck");

  chk_outside_clock_select_follows: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    mode_wr |=> cfg_o.outside_clock_select
      == $past(reg_wdata_i[CSRB_BIT_OUTSIDE_CLOCK_SELECT]))
    else $error("external clock select not taken");

  chk_sleep_gated: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) cfg_o.sleep |-> cfg_o.outside_clock_select)
    else $error("sleep held without external clock");

  chk_trim_follows: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    mode_wr ##1 !mode_wr[*2] |-> cfg_o.trim_mode_enable
      == $past(reg_wdata_i[CSRB_BIT_TRIM], 2))
    else $error("trim mode not held");

  chk_caps_upper_zero: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    reg_rd_i && reg_addr_i == CSRB_ADDR_CAPS
    |=> reg_rdata_o[CSRB_BYTE_W-1:CSRB_CAP_W] == '0
      && reg_rdata_o[CSRB_CAP_W-1:0] == $past(gain_caps_r[0]))
    else $error("gain capacitor byte wrong");

  chk_slot_hi_byte: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    reg_rd_i && reg_addr_i == addr_at(CSRB_ADDR_SLOTS, 1)
    |=> reg_rdata_o == CSRB_BYTE_W'($past(
      integ_slots_r[0][CSRB_SLOT_W-1:CSRB_BYTE_W])))
    else $error("slot high byte wrong");

  chk_result_hi_byte: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    reg_rd_i && reg_addr_i == addr_at(CSRB_ADDR_RESULT, 1)
    |=> reg_rdata_o[CSRB_BYTE_W-1:HI_COUNT_W] == '0)
    else $error("result high byte has stray bits");

  chk_zero_starts: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    trig_wr && reg_wdata_i[CSRB_BIT_ZERO_TRIG] && !read_trig_r
      && !reg_wdata_i[CSRB_BIT_READ_TRIG] && !zero_trig_r && !busy_o
    |=> ##1 afe_start_o && afe_zero_mode_o)
    else $error("offset trigger did not start an offset run");

  chk_trig_upper_zero: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    reg_rd_i && reg_addr_i == CSRB_ADDR_TRIGGER
    |=> reg_rdata_o[CSRB_BYTE_W-1:CSRB_BIT_ZERO_TRIG+1] == '0)
    else $error("control byte has stray bits");

  chk_mode_upper_zero: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    reg_rd_i && reg_addr_i == CSRB_ADDR_MODE
    |=> reg_rdata_o[CSRB_BYTE_W-1:CSRB_BIT_OUTSIDE_CLOCK_SELECT+1] == '0)
    else $error("mode byte has stray bits");

  cov_colour_run: cover property (@(posedge sys_clk_i)
    disable iff (rst_i) afe_start_o && !afe_zero_mode_o ##[1:20] read_done);

  cov_offset_run: cover property (@(posedge sys_clk_i)
    disable iff (rst_i) afe_start_o && afe_zero_mode_o ##[1:20] zero_done);

  cov_both_pending: cover property (@(posedge sys_clk_i)
    disable iff (rst_i) read_trig_r && zero_trig_r);

  cov_sleep_on: cover property (@(posedge sys_clk_i)
    disable iff (rst_i) $rose(cfg_o.sleep));

endmodule

// [logic/csrb_pkg.sv]
package csrb_pkg;

  // channel layout: red, green, blue, white in address order
  localparam int CSRB_CHANNELS = 4;
  localparam int CSRB_BYTE_W = 8;
  localparam int CSRB_ADDR_W = 8;
  localparam int CSRB_CAP_W = 4;
  localparam int CSRB_SLOT_W = 12;
  localparam int CSRB_COUNT_W = 10;
  localparam int CSRB_MAG_W = 7;

  // register addresses, one byte each
  localparam logic [CSRB_ADDR_W-1:0] CSRB_ADDR_TRIGGER = 8'h00;
  localparam logic [CSRB_ADDR_W-1:0] CSRB_ADDR_MODE = 8'h01;
  localparam logic [CSRB_ADDR_W-1:0] CSRB_ADDR_CAPS = 8'h06;
  localparam logic [CSRB_ADDR_W-1:0] CSRB_ADDR_SLOTS = 8'h0A;
  localparam logic [CSRB_ADDR_W-1:0] CSRB_ADDR_RESULT = 8'h40;
  localparam logic [CSRB_ADDR_W-1:0] CSRB_ADDR_ZERO = 8'h48;

  // field positions
  localparam int CSRB_BIT_READ_TRIG = 0;
  localparam int CSRB_BIT_ZERO_TRIG = 1;
  localparam int CSRB_BIT_TRIM = 0;
  localparam int CSRB_BIT_SLEEP = 1;
  localparam int CSRB_BIT_OUTSIDE_CLOCK_SELECT = 2;
  localparam int CSRB_BIT_SIGN = 7;

  // reset values
  localparam logic [CSRB_CAP_W-1:0] CSRB_CAP_RESET = 4'hF;
  localparam logic [CSRB_SLOT_W-1:0] CSRB_SLOT_RESET = 12'h000;
  localparam logic [CSRB_COUNT_W-1:0] CSRB_COUNT_RESET = 10'h000;
  localparam logic [CSRB_BYTE_W-1:0] CSRB_ZERO_RESET = 8'h00;

  typedef struct packed {
    logic outside_clock_select;
    logic sleep;
    logic trim_mode_enable;
    logic [CSRB_CHANNELS-1:0][CSRB_CAP_W-1:0] gain_caps;
    logic [CSRB_CHANNELS-1:0][CSRB_SLOT_W-1:0] integ_slots;
  } csrb_cfg_t;

  typedef struct packed {
    logic [CSRB_CHANNELS-1:0][CSRB_COUNT_W-1:0] count;
  } csrb_count_t;

  // sign in bit 7, magnitude in bits 6..0
  typedef struct packed {
    logic [CSRB_CHANNELS-1:0][CSRB_BYTE_W-1:0] level;
  } csrb_zero_t;

  typedef enum logic [2:0] {
    CSRB_IDLE = 3'b001,
    CSRB_RUN_READ = 3'b010,
    CSRB_RUN_ZERO = 3'b100
  } csrb_state_t;

endpackage

// [logic/csrb_measure_seq.sv]
`timescale 1ns/10ps
module csrb_measure_seq (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // pending triggers
  input wire logic read_trig_i,
  input wire logic zero_trig_i,
  // converter handshake
  input wire logic afe_done_i,
  output logic afe_start_o,
  output logic afe_zero_mode_o,
  // completion
  output logic read_done_o,
  output logic zero_done_o,
  output logic busy_o
);
  import csrb_pkg::*;

  csrb_state_t state_r;
  csrb_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CSRB_IDLE: begin
        // colour reading goes first when both are pending
        if (read_trig_i) begin
          state_nxt = CSRB_RUN_READ;
        end else if (zero_trig_i) begin
          state_nxt = CSRB_RUN_ZERO;
        end
      end
      CSRB_RUN_READ: begin
        if (afe_done_i) begin
          state_nxt = CSRB_IDLE;
        end
      end
      CSRB_RUN_ZERO: begin
        if (afe_done_i) begin
          state_nxt = CSRB_IDLE;
        end
      end
      default: begin
        state_nxt = CSRB_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= CSRB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      afe_start_o <= 1'b0;
      afe_zero_mode_o <= 1'b0;
    end else begin
      afe_start_o <= (state_r == CSRB_IDLE) && (state_nxt != CSRB_IDLE);
      if (state_r == CSRB_IDLE && state_nxt != CSRB_IDLE) begin
        afe_zero_mode_o <= (state_nxt == CSRB_RUN_ZERO);
      end
    end
  end

  // done outside a run is ignored
  assign read_done_o = (state_r == CSRB_RUN_READ) && afe_done_i;
  assign zero_done_o = (state_r == CSRB_RUN_ZERO) && afe_done_i;
  assign busy_o = (state_r != CSRB_IDLE);

  chk_start_single_pulse: assert property (@(posedge sys_clk_i)
    disable iff (rst_i) afe_start_o |=> !afe_start_o)
    else $error("converter start longer than one cycle");

  chk_start_mode_zero: assert property (@(posedge sys_clk_i)
    disable iff (rst_i)
    $rose(state_r == CSRB_RUN_ZERO) |-> afe_start_o && afe_zero_mode_o)
    else $error("offset run started without offset mode");

endmodule

// [verification/csrb_afe_model.sv]
`timescale 1ns/10ps
module csrb_afe_model (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // run request
  input wire logic afe_start_i,
  input wire logic afe_zero_mode_i,
  input wire logic [7:0] delay_i,
  // values to hand back
  input wire csrb_pkg::csrb_count_t count_val_i,
  input wire csrb_pkg::csrb_zero_t zero_val_i,
  // answer
  output logic afe_done_o,
  output csrb_pkg::csrb_count_t afe_count_o,
  output csrb_pkg::csrb_zero_t afe_zero_o
);
  import csrb_pkg::*;

  logic run_r;
  logic zero_r;
  logic [7:0] wait_r;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_r <= 1'b0;
      zero_r <= 1'b0;
      wait_r <= 8'h00;
      afe_done_o <= 1'b0;
    end else begin
      afe_done_o <= 1'b0;
      if (afe_start_i) begin
        run_r <= 1'b1;
        zero_r <= afe_zero_mode_i;
        wait_r <= delay_i;
      end else if (run_r) begin
        if (wait_r == 8'h00) begin
          run_r <= 1'b0;
          afe_done_o <= 1'b1;
        end else begin
          wait_r <= wait_r - 8'h01;
        end
      end
    end
  end

  // data only valid with done; inverted otherwise so stale capture shows
  assign afe_count_o = (afe_done_o && !zero_r) ? count_val_i : ~count_val_i;
  assign afe_zero_o = (afe_done_o && zero_r) ? zero_val_i : ~zero_val_i;
endmodule

// [verification/csrb_register_bank_test.sv]
`timescale 1ns/10ps
module csrb_register_bank_test;
  import csrb_pkg::*;

  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic afe_start_o;
  logic afe_zero_mode_o;
  logic afe_done_i;
  csrb_count_t afe_count_i;
  csrb_zero_t afe_zero_i;
  csrb_cfg_t cfg_o;
  logic busy_o;
  logic [7:0] delay_r = 8'h14;
  csrb_count_t count_val = {10'h3FF, 10'h2A5, 10'h100, 10'h0C3};
  csrb_zero_t zero_val = {8'h7F, 8'h80, 8'h85, 8'h12};
  logic [7:0] mode_wr [5] = '{8'h01, 8'h02, 8'h06, 8'hFF, 8'h02};
  logic [7:0] mode_rd [5] = '{8'h01, 8'h00, 8'h06, 8'h07, 8'h00};
  logic [7:0] start_log = 8'h00;
  int starts = 0;
  int starts_at = 0;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;

  always #2.5 sys_clk_i = ~sys_clk_i;

  csrb_register_bank dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .afe_start_o(afe_start_o),
    .afe_zero_mode_o(afe_zero_mode_o), .afe_done_i(afe_done_i),
    .afe_count_i(afe_count_i), .afe_zero_i(afe_zero_i), .cfg_o(cfg_o),
    .busy_o(busy_o));

  csrb_afe_model afe (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .afe_start_i(afe_start_o),
    .afe_zero_mode_i(afe_zero_mode_o), .delay_i(delay_r),
    .count_val_i(count_val), .zero_val_i(zero_val),
    .afe_done_o(afe_done_i), .afe_count_o(afe_count_i),
    .afe_zero_o(afe_zero_i));

  // record run kinds in start order
  always @(posedge sys_clk_i) begin
    if (afe_start_o === 1'b1) begin
      start_log <= {start_log[6:0], afe_zero_mode_o};
      starts <= starts + 1;
    end
  end

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    reg_read(a, d);
    check({8'h00, d}, {8'h00, exp});
  endtask

  // poll triggers as completion flags, bounded
  task automatic wait_clear();
    logic [7:0] d;
    int n;
    n = 0;
    d = 8'hFF;
    while (d[1:0] !== 2'b00 && n < 200) begin
      reg_read(CSRB_ADDR_TRIGGER, d);
      n++;
    end
    check({14'h0000, d[1:0]}, 16'h0000);
  endtask

  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    read_check(CSRB_ADDR_TRIGGER, 8'h00);
    read_check(CSRB_ADDR_MODE, 8'h00);
    for (int i = 0; i < 4; i++) begin
      read_check(CSRB_ADDR_CAPS + 8'(i), 8'h0F);
    end
    for (int i = 0; i < 8; i++) begin
      read_check(CSRB_ADDR_SLOTS + 8'(i), 8'h00);
    end
    for (int i = 0; i < 12; i++) begin
      read_check(CSRB_ADDR_RESULT + 8'(i), 8'h00);
    end
    $display("test reset values done");

    for (int i = 0; i < 4; i++) begin
      reg_write(CSRB_ADDR_CAPS + 8'(i), 8'hF0 | 8'(i));
      read_check(CSRB_ADDR_CAPS + 8'(i), 8'(i));
      check({12'h000, cfg_o.gain_caps[i]}, 16'(i));
      reg_write(CSRB_ADDR_SLOTS + 8'(2 * i), 8'h5A + 8'(i));
      reg_write(CSRB_ADDR_SLOTS + 8'(2 * i + 1), 8'hF3);
      read_check(CSRB_ADDR_SLOTS + 8'(2 * i), 8'h5A + 8'(i));
      read_check(CSRB_ADDR_SLOTS + 8'(2 * i + 1), 8'h03);
      check({4'h0, cfg_o.integ_slots[i]}, 16'h035A + 16'(i));
    end
    $display("test gain and slots done");

    for (int i = 0; i < 5; i++) begin
      reg_write(CSRB_ADDR_MODE, mode_wr[i]);
      read_check(CSRB_ADDR_MODE, mode_rd[i]);
      check({13'h0000, cfg_o.outside_clock_select, cfg_o.sleep,
             cfg_o.trim_mode_enable}, {8'h00, mode_rd[i]});
    end
    $display("test mode bits done");

    // slow converter: trigger must still read set mid-run
    reg_write(CSRB_ADDR_TRIGGER, 8'h01);
    read_check(CSRB_ADDR_TRIGGER, 8'h01);
    check({15'h0000, busy_o}, 16'h0001);
    wait_clear();
    for (int i = 0; i < 4; i++) begin
      read_check(CSRB_ADDR_RESULT + 8'(2 * i),
                 count_val.count[i][7:0]);
      read_check(CSRB_ADDR_RESULT + 8'(2 * i + 1),
                 {6'h00, count_val.count[i][9:8]});
    end
    reg_write(CSRB_ADDR_RESULT, 8'hFF);
    read_check(CSRB_ADDR_RESULT, count_val.count[0][7:0]);
    read_check(8'h20, 8'h00);
    reg_write(CSRB_ADDR_TRIGGER, 8'hFC);
    read_check(CSRB_ADDR_TRIGGER, 8'h00);
    $display("test colour run done");

    @(posedge sys_clk_i);
    delay_r <= 8'h00;
    reg_write(CSRB_ADDR_TRIGGER, 8'h02);
    wait_clear();
    for (int i = 0; i < 4; i++) begin
      read_check(CSRB_ADDR_ZERO + 8'(i), zero_val.level[i]);
    end
    $display("test offset run done");

    // both at once: colour run must precede offset run
    @(posedge sys_clk_i);
    starts_at = starts;
    reg_write(CSRB_ADDR_TRIGGER, 8'h03);
    wait_clear();
    check(16'(starts - starts_at), 16'h0002);
    check({14'h0000, start_log[1:0]}, 16'h0001);
    check({15'h0000, busy_o}, 16'h0000);
    $display("test both triggers done");
    give_verdict();
  end
endmodule
